// file: hdl/fpsb_map.svh
`ifndef FPSB_MAP_SVH
`define FPSB_MAP_SVH
// key matrix geometry
`define FPSB_NUM_LINES     6
`define FPSB_NUM_STEPS     6
`define FPSB_NUM_KEYS      19
// panel clock divider: /2 and /16 taps, tone counter /16 of 64 kHz
`define FPSB_DIV_W         4
`define FPSB_HALF_TAP      0
`define FPSB_TONE_CLK_TAP  3
`define FPSB_TONE_W        4
`define FPSB_TONE_TAP      3
// display drive
`define FPSB_NUM_GRIDS     11
`define FPSB_NUM_ANODES    14
`define FPSB_GRID_TOP      4'hA
// scan timing: settle time per step
`define FPSB_STEP_TIME_NS  1000
`define FPSB_CLK_PERIOD_NS 10
`define FPSB_STEP_CYCLES   ((`FPSB_STEP_TIME_NS + `FPSB_CLK_PERIOD_NS - 1) / `FPSB_CLK_PERIOD_NS)
`endif

// file: hdl/fpsb_pkg.sv
package fpsb_pkg;
    typedef enum logic [5:0] {
        FPSB_S1 = 6'h01,
        FPSB_S2 = 6'h02,
        FPSB_S3 = 6'h04,
        FPSB_S4 = 6'h08,
        FPSB_S5 = 6'h10,
        FPSB_S6 = 6'h20
    } fpsb_step_t;
    typedef struct packed {
        logic [5:0] oe_n;
        logic [5:0] dout;
    } fpsb_lines_t;
    typedef struct packed {
        logic [10:0] grid;
        logic [13:0] anode;
    } fpsb_disp_t;
endpackage

// file: hdl/fpsb_clk_div.sv
`timescale 1ns/1ps
`include "fpsb_map.svh"
module fpsb_clk_div
    import fpsb_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic panel_serial_clock,
    input  wire logic beep_en,
    output logic      controller_half_clock,
    output logic      tone_out
);
    logic [`FPSB_DIV_W-1:0]  div_r;
    logic [`FPSB_TONE_W-1:0] tone_r;
    logic                    ps_d_r;
    logic                    tone_counter_clear;
    logic                    ps_rise;
    logic                    tick64;

    assign ps_rise = panel_serial_clock & ~ps_d_r;
    assign tick64  = ps_rise && (div_r == {`FPSB_DIV_W{1'b1}});
    assign tone_counter_clear = ~beep_en;

    // edge detect on panel clock; counters advance on its rising edges
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ps_d_r <= 1'b0;
        end else begin
            ps_d_r <= panel_serial_clock;
        end
    end

    // free-running divider never held, so the controller clock always runs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '0;
        end else if (ps_rise) begin
            div_r <= div_r + 1'b1;
        end
    end

    // tone counter held clear while the beeper is off
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tone_r <= '0;
        end else if (tone_counter_clear) begin
            tone_r <= '0;
        end else if (tick64) begin
            tone_r <= tone_r + 1'b1;
        end
    end

    assign controller_half_clock = div_r[`FPSB_HALF_TAP];
    assign tone_out              = tone_r[`FPSB_TONE_TAP];

    a_tone_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !beep_en |=> tone_r == '0)
        else $error("tone counter not cleared");
    a_half_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ps_rise |=> controller_half_clock != $past(controller_half_clock))
        else $error("half clock did not toggle");
    a_tone_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        beep_en && tick64 |=> tone_r == $past(tone_r) + 4'h1 || !beep_en)
        else $error("tone counter did not advance");
endmodule

// file: hdl/fpsb_panel.sv
`timescale 1ns/1ps
`include "fpsb_map.svh"
module fpsb_panel
    import fpsb_pkg::*;
#(
    parameter int STEP_CYCLES = `FPSB_STEP_CYCLES
)(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [5:0]  key_line_i,
    output logic [5:0]       key_line_o,
    output logic [5:0]       key_line_oe_n,
    output logic [18:0]      keys_closed,
    output logic             keys_valid,
    input  wire logic        panel_serial_clock,
    output logic             controller_half_clock,
    input  wire logic        beep_en,
    output logic             speaker,
    input  wire logic        grid_advance,
    input  wire logic [13:0] anode_data,
    output logic [10:0]      grid,
    output logic [13:0]      anode,
    input  wire logic        panel_reset_n,
    output logic             disp_proc_rst,
    output logic             watchdog_fault
);
    localparam int CW = $clog2(STEP_CYCLES + 1);

    fpsb_step_t   step_r;
    fpsb_lines_t  lines_r;
    logic [CW-1:0] cnt_r;
    logic [18:0]  acc_r;
    logic [18:0]  acc_nxt;
    logic         step_end;
    logic         half_clk;
    logic         tone;
    logic [3:0]   grid_idx_r;
    logic         local_reset_n;

    assign step_end = (cnt_r == CW'(STEP_CYCLES - 1));

    // dwell counter: each step holds long enough for pull-ups to settle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else if (step_end) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // six-step sequencer wraps to step one after step six
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            step_r <= FPSB_S1;
        end else if (step_end) begin
            case (step_r)
                FPSB_S1: step_r <= FPSB_S2;
                FPSB_S2: step_r <= FPSB_S3;
                FPSB_S3: step_r <= FPSB_S4;
                FPSB_S4: step_r <= FPSB_S5;
                FPSB_S5: step_r <= FPSB_S6;
                default: step_r <= FPSB_S1;
            endcase
        end
    end

    // line drive for the next step; oe_n low means driving the strobe low
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lines_r <= '{oe_n: 6'h3F, dout: 6'h00};
        end else if (step_end) begin
            lines_r.dout <= 6'h00;
            case (step_r)
                FPSB_S1: lines_r.oe_n <= 6'h3E;
                FPSB_S2: lines_r.oe_n <= 6'h3D;
                FPSB_S3: lines_r.oe_n <= 6'h3B;
                FPSB_S4: lines_r.oe_n <= 6'h37;
                FPSB_S5: lines_r.oe_n <= 6'h2F;
                default: lines_r.oe_n <= 6'h3F;
            endcase
        end
    end

    // sample the sensed lines at the end of each step except step five; only lines above
    // the strobe are read, so lower high-impedance lines never count
    always_comb begin
        acc_nxt = acc_r;
        case (step_r)
            FPSB_S1: acc_nxt[5:0]   = ~key_line_i;
            FPSB_S2: acc_nxt[10:6]  = ~key_line_i[5:1];
            FPSB_S3: acc_nxt[14:11] = ~key_line_i[5:2];
            FPSB_S4: acc_nxt[17:15] = ~key_line_i[5:3];
            FPSB_S5: acc_nxt        = acc_r;
            default: acc_nxt[18]    = ~key_line_i[5];
        endcase
    end

    // accumulate one cycle, publish the set when step six completes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r       <= '0;
            keys_closed <= '0;
            keys_valid  <= 1'b0;
        end else begin
            keys_valid <= 1'b0;
            if (step_end) begin
                acc_r <= acc_nxt;
                if (step_r == FPSB_S6) begin
                    keys_closed <= acc_nxt;
                    keys_valid  <= 1'b1;
                    acc_r       <= '0;
                end
            end
        end
    end

    assign key_line_o    = lines_r.dout;
    assign key_line_oe_n = lines_r.oe_n;

    fpsb_clk_div u_div (
        .clk_sys               (clk_sys),
        .sys_rst               (sys_rst),
        .panel_serial_clock    (panel_serial_clock),
        .beep_en               (beep_en),
        .controller_half_clock (half_clk),
        .tone_out              (tone)
    );

    // register divider outputs so top outputs come from flops
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            controller_half_clock <= 1'b0;
            speaker               <= 1'b0;
        end else begin
            controller_half_clock <= half_clk;
            speaker               <= tone & beep_en;
        end
    end

    // grid sequencer: one grid at a time, counting down from the top grid
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            grid_idx_r <= `FPSB_GRID_TOP;
        end else if (grid_advance) begin
            grid_idx_r <= (grid_idx_r == 4'h0) ? `FPSB_GRID_TOP : grid_idx_r - 4'h1;
        end
    end

    // grid stays off when no anode under it is lit, avoiding ghosting
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            grid  <= '0;
            anode <= '0;
        end else begin
            anode <= anode_data;
            grid  <= (|anode_data) ? (11'h001 << grid_idx_r) : 11'h000;
        end
    end

    // reset pass-through and watchdog held cleared
    assign local_reset_n = panel_reset_n;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            disp_proc_rst  <= 1'b1;
            watchdog_fault <= 1'b0;
        end else begin
            disp_proc_rst  <= ~local_reset_n;
            watchdog_fault <= 1'b0;
        end
    end

    a_one_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        step_r != FPSB_S1 |-> $countones(~key_line_oe_n) == 1)
        else $error("not exactly one strobe");
    a_step_one_input: assert property (@(posedge clk_sys) disable iff (sys_rst)
        step_r == FPSB_S1 |-> key_line_oe_n == 6'h3F)
        else $error("lines driven in step one");
    a_strobe_pos: assert property (@(posedge clk_sys) disable iff (sys_rst)
        step_r == FPSB_S4 |-> key_line_oe_n == 6'h3B)
        else $error("wrong strobe line");
    a_step_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        step_r == FPSB_S6 && step_end |=> step_r == FPSB_S1 && keys_valid)
        else $error("scan did not wrap");
    a_grid_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $countones(grid) <= 1)
        else $error("more than one grid on");
    a_grid_dark: assert property (@(posedge clk_sys) disable iff (sys_rst)
        anode == '0 |-> grid == '0)
        else $error("grid lit with no anode");
    a_reset_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !panel_reset_n |=> disp_proc_rst)
        else $error("display reset not passed");
    a_watchdog_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !watchdog_fault)
        else $error("watchdog asserted");
    a_silent: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !beep_en |=> !speaker)
        else $error("speaker active while disabled");
    a_strobe_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
        step_r == FPSB_S2 |-> key_line_oe_n == 6'h3E)
        else $error("strobe not on line one in step two");
    a_strobe_last: assert property (@(posedge clk_sys) disable iff (sys_rst)
        step_r == FPSB_S6 |-> key_line_oe_n == 6'h2F)
        else $error("strobe not on line five in step six");
    a_anode_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> anode == $past(anode_data))
        else $error("anode data not passed to anodes");
endmodule

// file: sim/fpsb_key_matrix.sv
`timescale 1ns/1ps
// far side of the scan: pulled-up key lines, keys to ground and between line pairs
module fpsb_key_matrix
    import fpsb_pkg::*;
(
    input  wire logic [5:0]  key_line_o,
    input  wire logic [5:0]  key_line_oe_n,
    input  wire logic [18:0] closed,
    output logic [5:0]       key_line_i
);
    logic [5:0] lvl;
    int         k;
    // released lines go to the pull-up level; two passes settle chained keys
    always_comb begin
        lvl = 6'h3F;
        for (int i = 0; i < 6; i++) begin
            if (!key_line_oe_n[i] && !key_line_o[i]) lvl[i] = 1'b0;
            if (closed[i]) lvl[i] = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            k = 6;
            // line 4 pairs with no higher line, so step five can never sense one
            for (int a = 0; a < 5; a++) begin
                for (int b = a + 1; b < 6; b++) begin
                    if (a != 3 && closed[k] && !(lvl[a] && lvl[b])) begin
                        lvl[a] = 1'b0;
                        lvl[b] = 1'b0;
                    end
                    if (a != 3) k++;
                end
            end
        end
        key_line_i = lvl;
    end
endmodule

// file: sim/front_panel_scan_and_beeper_bench.sv
`timescale 1ns/1ps
module front_panel_scan_and_beeper_bench;
    import fpsb_pkg::*;
    localparam int SC = 4;
    logic        clk_sys = 0, sys_rst = 1, panel_serial_clock = 0, beep_en = 0;
    logic        grid_advance = 0, panel_reset_n = 1, keys_valid, half_clk, speaker;
    logic        disp_proc_rst, watchdog_fault, adv, rst_prev;
    logic [5:0]  key_line_i, key_line_o, key_line_oe_n;
    logic [18:0] closed = 0, keys_closed;
    logic [13:0] anode_data = 0, anode, data_prev;
    logic [10:0] grid;
    int          n_errors = 0, n_checks = 0, cyc = 0, acc = 0, np = 0, nh = 0, ns = 0;
    int          n0, h0, idx;
    logic        pp = 0, ph = 0, pk = 0;

    fpsb_panel #(.STEP_CYCLES(SC)) i_fpsb_panel (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .key_line_i(key_line_i), .key_line_o(key_line_o), .key_line_oe_n(key_line_oe_n),
        .keys_closed(keys_closed), .keys_valid(keys_valid),
        .panel_serial_clock(panel_serial_clock), .controller_half_clock(half_clk),
        .beep_en(beep_en), .speaker(speaker), .grid_advance(grid_advance),
        .anode_data(anode_data), .grid(grid), .anode(anode), .panel_reset_n(panel_reset_n),
        .disp_proc_rst(disp_proc_rst), .watchdog_fault(watchdog_fault));
    fpsb_key_matrix i_fpsb_key_matrix (.key_line_o(key_line_o),
        .key_line_oe_n(key_line_oe_n), .closed(closed), .key_line_i(key_line_i));

    always #5 clk_sys = ~clk_sys;

    // phase accumulator gives 1.024 MHz on the falling edge, no fixed ratio to clk_sys
    always @(negedge clk_sys) begin
        acc = acc + 2048;
        if (acc >= 100000) begin
            acc = acc - 100000;
            panel_serial_clock = ~panel_serial_clock;
        end
        cyc++;
        if (cyc > 80000) begin
            n_errors++;
            results();
        end
    end

    // rising edges counted at the sampling edge, read back on the falling one
    always @(posedge clk_sys) begin
        if (panel_serial_clock && !pp) np++;
        if (half_clk && !ph) nh++;
        if (speaker && !pk) ns++;
        pp = panel_serial_clock;
        ph = half_clk;
        pk = speaker;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // strobe pattern of a scan step, 0 = all lines sensed
    function automatic logic [5:0] step_oe(input int s);
        return (s == 0) ? 6'h3F : 6'h3F & ~(6'h01 << (s - 1));
    endfunction

    // raw detections: a line grounded by its key also reads low in every later
    // step that senses it; exact for sets with no two keys sharing a line
    function automatic logic [18:0] exp_keys(input logic [18:0] set);
        logic [18:0] e;
        e = set;
        for (int l = 1; l < 6; l++) begin
            if (set[l]) begin
                e[5 + l] = 1'b1;
                if (l >= 2) e[9 + l] = 1'b1;
                if (l >= 3) e[12 + l] = 1'b1;
                if (l == 5) e[18] = 1'b1;
            end
        end
        return e;
    endfunction

    task automatic wait_valid();
        int t;
        t = 0;
        while (keys_valid !== 1'b1 && t < 100) begin
            @(negedge clk_sys);
            t++;
        end
        chk("keys_valid arrival", 1, keys_valid);
    endtask

    // first report is stale, the full scan after it must show the raw detections exp_keys gives for this key set
    task automatic scan_check(input logic [18:0] set);
        closed = set;
        @(negedge clk_sys);
        wait_valid();
        for (int c = 0; c < 6 * SC; c++) begin
            chk("key_line_oe_n", step_oe(c / SC), key_line_oe_n);
            chk("strobe level", 0, key_line_o & ~key_line_oe_n);
            chk("keys_valid", c == 0, keys_valid);
            @(negedge clk_sys);
        end
        chk("keys_valid period", 1, keys_valid);
        chk("keys_closed", exp_keys(set), keys_closed);
    endtask

    task automatic wait_tone();
        int s0;
        s0 = ns;
        for (int t = 0; t < 30000 && ns == s0; t++) @(negedge clk_sys);
        chk("tone edge", 1, ns - s0);
    endtask

    initial begin
        void'($urandom(91855));
        repeat (3) @(negedge clk_sys);
        chk("reset oe_n", 6'h3F, key_line_oe_n);
        chk("reset keys", 0, keys_closed);
        chk("reset proc rst", 1, disp_proc_rst);
        chk("reset grid", 0, grid);
        repeat (3) @(negedge clk_sys);
        sys_rst = 0;
        for (int i = 0; i < 19; i++) scan_check(19'h00001 << i);
        scan_check(19'h00000);
        repeat (6) scan_check(19'h00001 << ($urandom % 19));
        // display: random advances including back-to-back ones, blank data, reset pass-through
        idx = 10;
        for (int i = 0; i < 30; i++) begin
            adv = ($urandom % 4) != 0;
            grid_advance = adv;
            anode_data = (i == 7) ? 14'h0000 : 14'(($urandom % 16383) + 1);
            panel_reset_n = $urandom % 2;
            data_prev = anode_data;
            rst_prev = panel_reset_n;
            @(negedge clk_sys);
            chk("grid", (data_prev != 0) ? 11'h001 << idx : 11'h000, grid);
            chk("anode", data_prev, anode);
            chk("disp_proc_rst", !rst_prev, disp_proc_rst);
            chk("watchdog_fault", 0, watchdog_fault);
            if (adv) idx = (idx == 0) ? 10 : idx - 1;
        end
        grid_advance = 0;
        // held silent, then a long beep as after a bad key
        n0 = ns;
        repeat (3000) @(negedge clk_sys);
        chk("silent tone", 0, ns - n0);
        beep_en = 1;
        wait_tone();
        n0 = np;
        h0 = nh;
        wait_tone();
        chk("panel per tone", 256, np - n0);
        chk("half per tone", 128, nh - h0);
        beep_en = 0;
        repeat (8) @(negedge clk_sys);
        n0 = ns;
        for (int t = 0; t < 3000; t++) begin
            chk("speaker cleared", 0, speaker);
            @(negedge clk_sys);
        end
        chk("silent after beep", 0, ns - n0);
        results();
    end
endmodule
